// File: src/psq_consts.svh
// constants of the sleep-side power sequencer configuration block
// assumes a 32-bit APB slave with a 12-bit byte address
`ifndef PSQ_CONSTS_SVH
`define PSQ_CONSTS_SVH

// register byte offsets
`define PSQ_OFS_SLEEP_ONE 12'h01C
`define PSQ_OFS_SLEEP_TWO 12'h020
`define PSQ_OFS_STATUS 12'h024

// per-state register fields
`define PSQ_DWELL_MSB 20
`define PSQ_DWELL_LSB 16
`define PSQ_BIT_CLK_OFF 14
`define PSQ_BIT_AN_PFM 9
`define PSQ_BIT_CORE_PFM 8
`define PSQ_BIT_IO_EN 5
`define PSQ_BIT_PLL_EN 4
`define PSQ_BIT_AN_EN 1
`define PSQ_BIT_CORE_EN 0
`define PSQ_WR_MASK 32'h001F4331

// status register fields
`define PSQ_STATE_MSB 18
`define PSQ_STATE_LSB 16
`define PSQ_PREV_IO 29
`define PSQ_PREV_PLL 28
`define PSQ_PREV_AN 25
`define PSQ_PREV_CORE 24

// reset values (dwell field added from the module parameter)
`define PSQ_SLEEP_ONE_RST 32'h00000022
`define PSQ_SLEEP_TWO_RST 32'h00000002
`define PSQ_PREV_RST 4'h2
`define PSQ_DWELL_RST 5'h10

`endif

// File: src/psq_pkg.sv
// types shared by the sleep-side power sequencer configuration block
// assumes nothing beyond a SystemVerilog package scope
package psq_pkg;

   // sequencer states, one-hot
   typedef enum logic [7:0] {
      ST_RESET = 8'h01,
      ST_ASLEEP = 8'h02,
      ST_WAKE1 = 8'h04,
      ST_WAKE2 = 8'h08,
      ST_AWAKE_WAIT = 8'h10,
      ST_AWAKE = 8'h20,
      ST_SLEEP1 = 8'h40,
      ST_SLEEP2 = 8'h80
   } psq_state_type;

   // supply configuration applied in one state
   typedef struct packed {
      logic tile_clk_off;
      logic analogue_pfm;
      logic core_pfm;
      logic io_supply_en;
      logic pll_supply_en;
      logic analogue_buck_en;
      logic core_buck_en;
   } psq_cfg_type;

endpackage

// File: src/psq_sleep_cfg.sv
// sleep-phase configuration registers, sequencer state and status word
// assumes an APB master on pclk and supply-good levels from analogue pins
`timescale 1ns/1ps
`include "psq_consts.svh"

// Operation
// [R1] five-bit log2 dwell field per sleep phase, 2^N cycles, resets to 16
// [R2] each sleep phase applies the settings of its own register
// [R3] bit 14 gates the processor tile clock in that state, reset 0
// [R4] bit 9 picks analogue converter modulation, 1 is pulse frequency, reset 0
// [R5] bit 8 picks core converter modulation, 1 is pulse frequency, reset 0
// [R6] bit 5 enables io supply, reset 1 in phase one, 0 in two
// [R7] bit 4 enables pll regulator, reset 0 in both phases
// [R8] bit 1 reads 1 and ignores writes
// [R9] bit 0 enables core converter, writable, reset 0
// [R10] status bits 18:16 report the state code 0 to 7
// [R11] status bits 29,28,25,24 show supplies of the previous state
// [R12] low status bits mirror the configuration applied now
// [R13] waking phases leave only after dwell and all enabled supplies good
// [R14] phase one expiry goes to phase two, phase two expiry to asleep
module psq_sleep_cfg
   import psq_pkg::*;
#(
   parameter logic [4:0] DWELL_LOG2_RESET = `PSQ_DWELL_RST
) (
   // clock, reset, enable
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // sequencer requests from same-clock logic
   input wire logic sleep_req,
   input wire logic wake_req,
   // settings of the other states
   input wire psq_cfg_type asleep_cfg,
   input wire psq_cfg_type wake_one_cfg,
   input wire psq_cfg_type wake_two_cfg,
   input wire psq_cfg_type awake_cfg,
   input wire logic [4:0] wake_one_log2,
   input wire logic [4:0] wake_two_log2,
   // supply good pins: io, pll, analogue, core
   input wire logic [3:0] supply_good_pin,
   // applied configuration
   output psq_cfg_type applied_cfg
);

   // decode a per-state register word into its configuration
   function automatic psq_cfg_type word_to_cfg(input logic [31:0] w);
      psq_cfg_type c;
      c.tile_clk_off = w[`PSQ_BIT_CLK_OFF];
      c.analogue_pfm = w[`PSQ_BIT_AN_PFM];
      c.core_pfm = w[`PSQ_BIT_CORE_PFM];
      c.io_supply_en = w[`PSQ_BIT_IO_EN];
      c.pll_supply_en = w[`PSQ_BIT_PLL_EN];
      c.analogue_buck_en = w[`PSQ_BIT_AN_EN];
      c.core_buck_en = w[`PSQ_BIT_CORE_EN];
      return c;
   endfunction

   // place a configuration at the per-state bit positions
   function automatic logic [31:0] cfg_to_word(input psq_cfg_type c);
      logic [31:0] w;
      w = 32'h00000000;
      w[`PSQ_BIT_CLK_OFF] = c.tile_clk_off;
      w[`PSQ_BIT_AN_PFM] = c.analogue_pfm;
      w[`PSQ_BIT_CORE_PFM] = c.core_pfm;
      w[`PSQ_BIT_IO_EN] = c.io_supply_en;
      w[`PSQ_BIT_PLL_EN] = c.pll_supply_en;
      w[`PSQ_BIT_AN_EN] = c.analogue_buck_en;
      w[`PSQ_BIT_CORE_EN] = c.core_buck_en;
      return w;
   endfunction

   // supply enables in pin order io, pll, analogue, core
   function automatic logic [3:0] cfg_supplies(input psq_cfg_type c);
      return {c.io_supply_en, c.pll_supply_en, c.analogue_buck_en, c.core_buck_en};
   endfunction

   // last count of a 2^n cycle dwell
   function automatic logic [31:0] dwell_limit(input logic [4:0] n);
      return (32'h00000001 << n) - 32'h00000001;
   endfunction

   // status code of a state
   function automatic logic [2:0] state_code(input psq_state_type s);
      logic [2:0] k;
      case (s)
         ST_RESET: k = 3'h0;
         ST_ASLEEP: k = 3'h1;
         ST_WAKE1: k = 3'h2;
         ST_WAKE2: k = 3'h3;
         ST_AWAKE_WAIT: k = 3'h4;
         ST_AWAKE: k = 3'h5;
         ST_SLEEP1: k = 3'h6;
         ST_SLEEP2: k = 3'h7;
         default: k = 3'h0;
      endcase
      return k;
   endfunction

   logic [31:0] sleep_one_reg;
   logic [31:0] sleep_two_reg;
   logic [3:0] prev_reg;
   psq_cfg_type applied_reg;
   psq_state_type state_reg;
   psq_state_type state_next;
   logic [31:0] dwell_cnt_reg;
   logic [4:0] dwell_log2;
   logic dwell_hit;
   psq_cfg_type cfg_now;
   logic [3:0] good_s1_reg;
   logic [3:0] good_s2_reg;
   logic [3:0] good_s3_reg;
   logic [3:0] good_reg;
   logic all_good;
   logic arm_reg;
   logic [31:0] prdata_reg;
   logic [31:0] stat_word;
   logic hit_one;
   logic hit_two;
   logic hit_stat;
   logic wr_take;

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // supply good pins are asynchronous: three stages, a change counts when stages two and three agree
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         good_s1_reg <= 4'h0;
         good_s2_reg <= 4'h0;
         good_s3_reg <= 4'h0;
         good_reg <= 4'h0;
      end else if (ce) begin
         good_s1_reg <= supply_good_pin;
         good_s2_reg <= good_s1_reg;
         good_s3_reg <= good_s2_reg;
         good_reg <= (good_s2_reg & good_s3_reg) | (good_reg & (good_s2_reg | good_s3_reg));
      end
   end

   // configuration of the current state; reset applies nothing
   always_comb begin
      cfg_now = '0;
      dwell_log2 = 5'h00;
      case (state_reg)
         ST_RESET: cfg_now = '0;
         ST_ASLEEP: cfg_now = asleep_cfg;
         ST_WAKE1: begin
            cfg_now = wake_one_cfg;
            dwell_log2 = wake_one_log2;
         end
         ST_WAKE2: begin
            cfg_now = wake_two_cfg;
            dwell_log2 = wake_two_log2;
         end
         ST_AWAKE_WAIT: cfg_now = awake_cfg;
         ST_AWAKE: cfg_now = awake_cfg;
         ST_SLEEP1: begin
            cfg_now = word_to_cfg(sleep_one_reg); // [R2]
            dwell_log2 = sleep_one_reg[`PSQ_DWELL_MSB:`PSQ_DWELL_LSB]; // [R1]
         end
         ST_SLEEP2: begin
            cfg_now = word_to_cfg(sleep_two_reg); // [R2]
            dwell_log2 = sleep_two_reg[`PSQ_DWELL_MSB:`PSQ_DWELL_LSB]; // [R1]
         end
         default: cfg_now = '0;
      endcase
   end

   // uses the current state's enables, not the lagging applied copy
   assign all_good = &(good_reg | ~cfg_supplies(cfg_now));
   assign dwell_hit = (dwell_cnt_reg == dwell_limit(dwell_log2));

   // state transitions
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_RESET: state_next = ST_WAKE1;
         ST_ASLEEP: if (wake_req) state_next = ST_WAKE1;
         ST_WAKE1: if (dwell_hit && all_good) state_next = ST_WAKE2; // [R13]
         ST_WAKE2: if (dwell_hit && all_good) state_next = ST_AWAKE_WAIT; // [R13]
         ST_AWAKE_WAIT: if (all_good) state_next = ST_AWAKE;
         ST_AWAKE: if (sleep_req) state_next = ST_SLEEP1;
         ST_SLEEP1: if (dwell_hit) state_next = ST_SLEEP2; // [R14]
         ST_SLEEP2: if (dwell_hit) state_next = ST_ASLEEP; // [R14]
         default: state_next = ST_RESET;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= ST_RESET;
      end else if (ce) begin
         state_reg <= state_next;
      end
   end

   // dwell counter restarts on entry and holds at its last count
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dwell_cnt_reg <= 32'h00000000;
      end else if (ce) begin
         if (state_next != state_reg) begin
            dwell_cnt_reg <= 32'h00000000;
         end else if (!dwell_hit) begin
            dwell_cnt_reg <= dwell_cnt_reg + 32'h00000001; // [R1]
         end
      end
   end

   // applied configuration follows the state one cycle later
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         applied_reg <= '0;
      end else if (ce) begin
         applied_reg <= cfg_now; // [R2] [R3] [R4] [R5] [R6] [R7] [R9]
      end
   end

   assign applied_cfg = applied_reg;

   // supplies of the state being left
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev_reg <= `PSQ_PREV_RST;
      end else if (ce && state_next != state_reg) begin
         prev_reg <= cfg_supplies(cfg_now); // [R11]
      end
   end

   // address decode; misaligned addresses miss
   assign hit_one = (paddr == `PSQ_OFS_SLEEP_ONE);
   assign hit_two = (paddr == `PSQ_OFS_SLEEP_TWO);
   assign hit_stat = (paddr == `PSQ_OFS_STATUS);
   assign wr_take = pready && pwrite;

   // per-state registers; bit 1 sits outside the write mask
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sleep_one_reg <= `PSQ_SLEEP_ONE_RST | {11'h000, DWELL_LOG2_RESET, 16'h0000}; // [R1] [R6] [R7]
         sleep_two_reg <= `PSQ_SLEEP_TWO_RST | {11'h000, DWELL_LOG2_RESET, 16'h0000}; // [R1] [R6] [R7]
      end else if (wr_take) begin
         if (hit_one) begin
            sleep_one_reg <= (sleep_one_reg & ~`PSQ_WR_MASK) | (pwdata & `PSQ_WR_MASK); // [R8] [R9]
         end
         if (hit_two) begin
            sleep_two_reg <= (sleep_two_reg & ~`PSQ_WR_MASK) | (pwdata & `PSQ_WR_MASK); // [R8] [R9]
         end
      end
   end

   // status word
   always_comb begin
      stat_word = cfg_to_word(applied_reg); // [R12]
      stat_word[`PSQ_STATE_MSB:`PSQ_STATE_LSB] = state_code(state_reg); // [R10]
      stat_word[`PSQ_PREV_IO] = prev_reg[3]; // [R11]
      stat_word[`PSQ_PREV_PLL] = prev_reg[2];
      stat_word[`PSQ_PREV_AN] = prev_reg[1];
      stat_word[`PSQ_PREV_CORE] = prev_reg[0];
   end

   // read data is captured in the first enabled cycle of a transfer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         arm_reg <= 1'b0;
         prdata_reg <= 32'h00000000;
      end else if (ce) begin
         if (pready) begin
            arm_reg <= 1'b0;
         end else if (psel && !arm_reg) begin
            arm_reg <= 1'b1;
            prdata_reg <= hit_one ? sleep_one_reg : hit_two ? sleep_two_reg : hit_stat ? stat_word : 32'h00000000;
         end
      end
   end

   // a low enable stretches the access phase
   assign pready = psel && penable && ce && arm_reg;
   assign pslverr = pready && !(hit_one || hit_two || hit_stat);
   assign prdata = prdata_reg;

   // checks
   a_sleep_one_apply: assert property ((ce && state_reg == ST_SLEEP1) |=> // [R2]
      applied_reg == word_to_cfg($past(sleep_one_reg)))
      else $error("phase one settings not applied");

   a_sleep_two_apply: assert property ((ce && state_reg == ST_SLEEP2) |=> // [R3] [R6]
      applied_reg.tile_clk_off == $past(sleep_two_reg[14]) && applied_reg.io_supply_en == $past(sleep_two_reg[5]))
      else $error("phase two clock gate or io enable wrong");

   a_modulation_apply: assert property ((ce && state_reg == ST_SLEEP2) |=> // [R4] [R5]
      {applied_reg.analogue_pfm, applied_reg.core_pfm} == $past(sleep_two_reg[9:8]))
      else $error("phase two modulation choice wrong");

   a_bit_one_fixed: assert property (sleep_one_reg[1] && sleep_two_reg[1]) // [R8]
      else $error("read-only converter enable changed");

   a_core_en_write: assert property ((wr_take && hit_one) |=> // [R9]
      sleep_one_reg[0] == $past(pwdata[0]))
      else $error("core converter enable not written");

   a_dwell_write: assert property ((wr_take && hit_two) |=> // [R1]
      sleep_two_reg[20:16] == $past(pwdata[20:16]))
      else $error("phase two dwell field not written");

   a_dwell_hold: assert property ((ce && state_reg == ST_SLEEP1 && // [R1]
      dwell_cnt_reg != dwell_limit(sleep_one_reg[20:16])) |=> state_reg == ST_SLEEP1)
      else $error("phase one left before dwell");

   a_sleep_order: assert property ((ce && state_reg == ST_SLEEP1 && dwell_hit) |=> // [R14]
      state_reg == ST_SLEEP2)
      else $error("phase one did not go to phase two");

   a_asleep_after: assert property ((ce && state_reg == ST_SLEEP2 && dwell_hit) |=> state_reg == ST_ASLEEP) // [R14]
      else $error("phase two did not go to asleep");

   a_wake_min: assert property ((ce && state_reg == ST_WAKE1 && !(dwell_hit && all_good)) |=> // [R13]
      state_reg == ST_WAKE1)
      else $error("waking phase left early");

   a_status_code: assert property ((state_reg == ST_SLEEP2) |-> stat_word[18:16] == 3'h7) // [R10]
      else $error("status code wrong for phase two");

   a_status_sleep_one: assert property ((state_reg == ST_SLEEP1) |-> stat_word[18:16] == 3'h6) // [R10]
      else $error("status code wrong for phase one");

   a_prev_flags: assert property ((ce && state_next != state_reg) |=> // [R11]
      {stat_word[29], stat_word[28], stat_word[25], stat_word[24]} == $past(cfg_supplies(cfg_now)))
      else $error("previous supply flags wrong");

   a_status_mirror: assert property ($changed(applied_reg) |-> // [R12]
      stat_word[14] == applied_reg.tile_clk_off && stat_word[9:8] == {applied_reg.analogue_pfm, applied_reg.core_pfm})
      else $error("status does not mirror applied settings");

endmodule

// File: bench/psq_sleep_cfg_test.sv
// self-checking bench for the sleep-side sequencer configuration block
// assumes the block's package and constants header on the include path
`timescale 1ns/1ps
`include "psq_consts.svh"

module psq_sleep_cfg_test
   import psq_pkg::*;
;
   logic pclk = 0;
   logic presetn = 0;
   logic ce = 1;
   logic psel = 0;
   logic penable = 0;
   logic pwrite = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic sleep_req = 0;
   logic wake_req = 0;
   psq_cfg_type asleep_cfg = 7'h42;
   psq_cfg_type wake_one_cfg = 7'h03;
   psq_cfg_type wake_two_cfg = 7'h07;
   psq_cfg_type awake_cfg = 7'h0F;
   psq_cfg_type applied_cfg;
   logic [3:0] supply_good_pin = 4'hF;
   int n_fail = 0;
   int checked = 0;
   int cycles = 0;
   int cnt;
   logic [33:0] q[$];
   logic [33:0] e;
   logic [31:0] w1, w2;
   logic [4:0] wake_one_log2 = 5'h01;
   logic [4:0] wake_two_log2 = 5'h01;

   psq_sleep_cfg dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .sleep_req(sleep_req), .wake_req(wake_req), .asleep_cfg(asleep_cfg),
      .wake_one_cfg(wake_one_cfg), .wake_two_cfg(wake_two_cfg), .awake_cfg(awake_cfg),
      .wake_one_log2(wake_one_log2), .wake_two_log2(wake_two_log2), .supply_good_pin(supply_good_pin),
      .applied_cfg(applied_cfg));

   always #20 pclk = ~pclk;

   task check(input logic [31:0] got, input logic [31:0] exp, input string what);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask

   // compare an applied supply setting
   task check_cfg(input psq_cfg_type got, input psq_cfg_type exp, input string what);
      check({25'h0, got}, {25'h0, exp}, what);
   endtask

   task finish_test;
      $display("comparisons %0d, mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // hang guard, runs are a few hundred cycles
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_fail++;
         finish_test;
      end
   end

   // taken transfers, judged at the rising edge that takes them, before its updates land
   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1) begin
         e = q.pop_front();
         check({31'h0, pslverr}, {31'h0, e[32]}, "error flag");
         if (!e[33]) check(prdata, e[31:0], "read data");
      end
   end

   // expected per-state setting from a phase register word; bit 1 always on
   function psq_cfg_type rc(input logic [31:0] w);
      return {w[14], w[9], w[8], w[5], w[4], 1'b1, w[0]};
   endfunction

   // expected status word from state code, applied and previous supplies
   function logic [31:0] stat(input logic [2:0] c, input psq_cfg_type a, input logic [3:0] p);
      return {2'b00, p[3:2], 2'b00, p[1:0], 5'h00, c, 1'b0, a[6], 4'h0, a[5:4], 2'b00, a[3:2], 2'b00, a[1:0]};
   endfunction

   // one apb transfer; stall drops ce during setup to force wait states
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic err,
            input logic [31:0] exp, input logic stall);
      int i;
      q.push_back({wr, err, exp});
      @(posedge pclk);
      psel <= 1;
      penable <= 0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      if (stall) ce <= 0;
      @(posedge pclk);
      penable <= 1;
      // ready is sampled at the rising edge; the request is released at that same edge
      for (i = 0; i < 50; i++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
         if (i == 1) ce <= 1;
      end
      if (i == 50) check(32'h0, 32'h1, "no ready");
      psel <= 0;
      penable <= 0;
   endtask

   // wait, bounded, for an applied setting, then compare it
   task wait_cfg(input psq_cfg_type c);
      for (int i = 0; i < 400 && applied_cfg !== c; i++) @(negedge pclk);
      check_cfg(applied_cfg, c, "applied setting");
   endtask

   initial begin
      void'($urandom(78975));
      @(posedge pclk);
      // random waking dwells, set while reset still holds
      wake_one_log2 <= 5'($urandom_range(3, 0));
      wake_two_log2 <= 5'($urandom_range(3, 0));
      repeat (7) @(posedge pclk);
      presetn <= 1;
      apb(0, `PSQ_OFS_SLEEP_ONE, 0, 0, 32'h00100022, 1);
      apb(0, `PSQ_OFS_SLEEP_TWO, 0, 0, 32'h00100002, 0);
      apb(0, 12'h028, 0, 1, 32'h0, 0);
      apb(1, 12'h01D, 32'hFFFFFFFF, 1, 32'h0, 0);
      apb(1, `PSQ_OFS_STATUS, 32'hFFFFFFFF, 0, 32'h0, 0);
      // phase one dwell 8, core on, io off; phase two dwell 128, core off
      w1 = ($urandom & 32'h00004310) | 32'h00030001;
      w2 = ($urandom & 32'h00000330) | 32'h00070000;
      apb(1, `PSQ_OFS_SLEEP_ONE, w1 | 32'hFFE0BCCC, 0, 32'h0, 0);
      apb(0, `PSQ_OFS_SLEEP_ONE, 0, 0, w1 | 32'h2, 0);
      apb(1, `PSQ_OFS_SLEEP_TWO, w2 | 32'hFFE0BCCC, 0, 32'h0, 0);
      apb(0, `PSQ_OFS_SLEEP_TWO, 0, 0, w2 | 32'h2, 0);
      wait_cfg(awake_cfg);
      // one-cycle request; a request left high would restart sleep after the wake test
      @(posedge pclk);
      sleep_req <= 1;
      @(posedge pclk);
      sleep_req <= 0;
      wait_cfg(rc(w1));
      cnt = 1;
      @(negedge pclk);
      while (applied_cfg === rc(w1) && cnt < 300) begin
         cnt++;
         @(negedge pclk);
      end
      check(cnt, 8, "phase one dwell");
      check_cfg(applied_cfg, rc(w2), "phase two setting");
      apb(0, `PSQ_OFS_STATUS, 0, 0, stat(3'h7, rc(w2), rc(w1) & 7'h0F), 0);
      wait_cfg(asleep_cfg);
      apb(0, `PSQ_OFS_STATUS, 0, 0, stat(3'h1, asleep_cfg, rc(w2) & 7'h0F), 0);
      // core supply not good: first waking phase must hold
      // the pin must be through the synchroniser before waking starts
      @(posedge pclk);
      supply_good_pin <= 4'hE;
      repeat (6) @(posedge pclk);
      wake_req <= 1;
      wait_cfg(wake_one_cfg);
      repeat (20) @(negedge pclk);
      check_cfg(applied_cfg, wake_one_cfg, "waking hold");
      @(posedge pclk);
      supply_good_pin <= 4'hF;
      wake_req <= 0;
      wait_cfg(awake_cfg);
      repeat (4) @(posedge pclk);
      check(q.size(), 0, "pending transfers");
      finish_test;
   end
endmodule
